// *** rtl/adc_host_if.sv ***
// parallel host interface of a sampling converter
// Notes on behaviour
// RL1: result is 12 bits, bit 11 most significant, bit 0 least.
// RL2: high_byte_select low drives all 12 result bits in parallel.
// RL3: high_byte_select high puts bits 11..8 on lines 3..0, lines 7..4 low.
// RL4: no conversion starts while high_byte_select is high at the request.
// RL5: start on read_convert fall with select low, byte select low, busy high.
// RL6: device_select_n high keeps every data line high impedance.
// RL7: host drives device_select_n low to convert and to read.
// RL8: busy low for the whole conversion, high again at its end.
// RL9: result valid when busy rises in convert mode.
// RL10: read_convert pulses ignored while busy is low.
// RL11: read mode: rising edge shows old result, falling edge converts.
// RL12: drivers on only while read_convert high and busy high and selected.
// RL13: counter holds busy low a fixed cycle count before loading latches.
`timescale 1ns/100ps
module adc_host_if
    import adc_host_pkg::*;
#(
    parameter int CONV_COUNT = CONV_CYCLES
)
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        read_convert,
    input  wire logic        device_select_n,
    input  wire logic        high_byte_select,
    input  wire logic [11:0] sample_in,
    output logic             busy,
    output logic      [11:0] data_out,
    output logic      [11:0] data_oe_n,
    output logic             sample_hold
);

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [0:0]
    {
        IDLE_S = 1'b0,
        CONV_S = 1'b1
    } state_type;

    typedef struct packed
    {
        logic [1:0]  rc_sync;
        logic [1:0]  cs_sync;
        logic [1:0]  hb_sync;
        logic        rc_prev;
        state_type   state;
        logic [11:0] cnt;
        logic [11:0] result;
        logic [11:0] data;
        logic        oe;
    } regs_type;

    regs_type s_r;
    regs_type s_nxt;

    logic rc_s;
    logic cs_n_s;
    logic hb_s;
    logic start;

    assign rc_s   = s_r.rc_sync[1];
    assign cs_n_s = s_r.cs_sync[1];
    assign hb_s   = s_r.hb_sync[1];

    // falling edge qualified by select, byte select and idle
    assign start = s_r.rc_prev && !rc_s && !cs_n_s && !hb_s
                   && (s_r.state == IDLE_S); // RL5 RL4 RL10 RL11

    // byte steering of the output lines
    function automatic logic [11:0] steer(input logic [11:0] r,
                                          input logic        hb);
        if (hb)
            steer = {r[11:8], 4'h0, r[11:8]}; // RL3
        else
            steer = r; // RL1 RL2
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s_nxt         = s_r;
        s_nxt.rc_sync = {s_r.rc_sync[0], read_convert};
        s_nxt.cs_sync = {s_r.cs_sync[0], device_select_n};
        s_nxt.hb_sync = {s_r.hb_sync[0], high_byte_select};
        s_nxt.rc_prev = rc_s;
        case (s_r.state)
            IDLE_S:
            begin
                if (start)
                begin
                    s_nxt.state = CONV_S;
                    s_nxt.cnt   = CNT_RESET;
                end
            end
            CONV_S:
            begin
                if (s_r.cnt == 12'(CONV_COUNT - 1)) // RL13
                begin
                    s_nxt.state  = IDLE_S; // RL8
                    s_nxt.result = sample_in; // RL9
                end
                else
                begin
                    s_nxt.cnt = s_r.cnt + 12'h001;
                end
            end
            default:
            begin
                s_nxt.state = IDLE_S;
            end
        endcase
        s_nxt.data = steer(s_nxt.result, hb_s);
        s_nxt.oe   = !cs_n_s && rc_s && (s_nxt.state == IDLE_S); // RL6 RL12
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r         <= '0;
            s_r.rc_sync <= 2'b00;
            s_r.cs_sync <= 2'b11;
            s_r.state   <= IDLE_S;
            s_r.result  <= RESULT_RESET;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign busy        = (s_r.state == IDLE_S); // RL8
    assign sample_hold = (s_r.state == CONV_S);
    assign data_out    = s_r.data;

    genvar gi;
    generate
        for (gi = 0; gi < RESULT_W; gi++)
        begin : g_oe
            assign data_oe_n[gi] = !s_r.oe;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    property p_start_busy;
        @(posedge clk_sys) disable iff (!rst_n)
        start |=> !busy;
    endproperty
    a_start_busy: assert property (p_start_busy) // RL5
        else $error("busy did not fall after start");

    property p_hb_blocks;
        @(posedge clk_sys) disable iff (!rst_n)
        (busy && hb_s) |=> busy;
    endproperty
    a_hb_blocks: assert property (p_hb_blocks) // RL4
        else $error("conversion started with byte select high");

    property p_busy_len;
        @(posedge clk_sys) disable iff (!rst_n)
        $fell(busy) |-> !busy [*8];
    endproperty
    a_busy_len: assert property (p_busy_len) // RL8
        else $error("busy low too short");

    property p_busy_ends;
        @(posedge clk_sys) disable iff (!rst_n)
        $fell(busy) |-> ##[1:200] busy;
    endproperty
    a_busy_ends: assert property (p_busy_ends) // RL13
        else $error("conversion did not end");

    property p_hiz_select;
        @(posedge clk_sys) disable iff (!rst_n)
        cs_n_s |=> (data_oe_n == 12'hFFF);
    endproperty
    a_hiz_select: assert property (p_hiz_select) // RL6
        else $error("drivers on while deselected");

    property p_hiz_busy;
        @(posedge clk_sys) disable iff (!rst_n)
        !busy |-> (data_oe_n == 12'hFFF);
    endproperty
    a_hiz_busy: assert property (p_hiz_busy) // RL12
        else $error("drivers on during conversion");

    property p_high_byte;
        @(posedge clk_sys) disable iff (!rst_n)
        (hb_s && busy && $past(busy)) |=>
            (data_out[7:4] == 4'h0 && data_out[3:0] == s_r.result[11:8]);
    endproperty
    a_high_byte: assert property (p_high_byte) // RL3
        else $error("high byte steering wrong");

    property p_full_word;
        @(posedge clk_sys) disable iff (!rst_n)
        (!hb_s && busy && $past(busy)) |=> (data_out == s_r.result);
    endproperty
    a_full_word: assert property (p_full_word) // RL2
        else $error("full word not presented");

    property p_result_at_rise;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(busy) |-> (s_r.result == $past(sample_in));
    endproperty
    a_result_at_rise: assert property (p_result_at_rise) // RL9
        else $error("result not loaded when busy rose");

    property p_oe_on;
        @(posedge clk_sys) disable iff (!rst_n)
        (!cs_n_s && rc_s && busy) |=> (data_oe_n == 12'h000);
    endproperty
    a_oe_on: assert property (p_oe_on) // RL11
        else $error("drivers off while read enabled");

    property p_hiz_rc_low;
        @(posedge clk_sys) disable iff (!rst_n)
        !rc_s |=> (data_oe_n == 12'hFFF);
    endproperty
    a_hiz_rc_low: assert property (p_hiz_rc_low) // RL12
        else $error("drivers on while read_convert low");

endmodule

// *** rtl/adc_host_pkg.sv ***
// constants for the converter host interface
package adc_host_pkg;
    localparam int          RESULT_W        = 12;
    localparam int          MSB_POS         = 11;
    localparam int          LSB_POS         = 0;
    localparam int          CLK_MHZ         = 50;
    localparam int          CONV_TIME_NS    = 2700;
    localparam int          CONV_CYCLES     = (CONV_TIME_NS * CLK_MHZ) / 1000;
    localparam logic [11:0] RESULT_RESET    = 12'h000;
    localparam logic [11:0] CNT_RESET       = 12'h000;
endpackage

// *** testbench/adc_parallel_host_interface_tb.sv ***
// self-checking bench for the converter host interface
`timescale 1ns/100ps
module adc_parallel_host_interface_tb;
    import adc_host_pkg::*;
    localparam int N = 10;
    logic clk_sys, rst_n, rc, cs_n, hb, busy, sh;
    logic [11:0] smp, dout, oe_n, bus, cap;
    int errors, checks;
    adc_host_if #(.CONV_COUNT(N)) adc_host_if_i (.clk_sys(clk_sys),
        .rst_n(rst_n), .read_convert(rc), .device_select_n(cs_n),
        .high_byte_select(hb), .sample_in(smp), .busy(busy),
        .data_out(dout), .data_oe_n(oe_n), .sample_hold(sh));
    host_bus_model host_bus_model_i (.clk_sys(clk_sys), .busy(busy),
        .data_out(dout), .data_oe_n(oe_n), .bus_level(bus),
        .captured(cap));
    ////////////////////////////////////////////////////////////////
    task cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #2;
    endtask
    task chk(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task conv(input logic [11:0] v, input bit poke);
        int n;
        n = 0;
        smp = v;
        cs_n = 0;
        hb = 0;
        rc = 1;
        cyc(4);
        rc = 0;
        cyc(2);
        rc = 1;
        for (int i = 0; i < 20 && busy !== 1'b0; i++) cyc(1);
        while (busy === 1'b0 && n < 40)
        begin
            if (n == 5)
            begin
                chk(oe_n, 12'hFFF);
                chk({11'h000, sh}, 12'h001);
            end
            if (poke && n < 6) rc = n[0];
            n++;
            cyc(1);
        end
        chk(12'(n), 12'(N));
        cyc(2);
        chk(cap, v);
    endtask
    task rd(input logic hv, input logic [11:0] exp);
        cs_n = 1;
        cyc(4);
        rc = 0;
        cyc(4);
        cs_n = 0;
        hb = hv;
        cyc(4);
        chk(oe_n, 12'hFFF);
        rc = 1;
        cyc(4);
        chk(oe_n, 12'h000);
        chk(bus, exp);
        cs_n = 1;
        cyc(4);
        chk(oe_n, 12'hFFF);
        rc = 0;
        hb = 0;
        cyc(4);
    endtask
    task refuse();
        hb = 1;
        cs_n = 0;
        rc = 1;
        cyc(4);
        rc = 0;
        cyc(8);
        chk({11'h000, busy}, 12'h001);
        cs_n = 1;
        hb = 0;
        cyc(4);
    endtask
    task results();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial
    begin
        #100000;
        errors++;
        results();
    end
    initial
    begin
        {errors, checks} = 0;
        {rc, hb, smp} = 0;
        cs_n = 1;
        rst_n = 0;
        cyc(8);
        rst_n = 1;
        cyc(4);
        chk(oe_n, 12'hFFF);
        chk({11'h000, busy}, 12'h001);
        conv(12'h5C3, 0);
        rd(0, 12'h5C3);
        conv(12'h3B6, 1);
        rd(1, 12'h303);
        refuse();
        conv(12'hFFF, 0);
        rd(1, 12'hF0F);
        results();
    end
endmodule

// *** testbench/host_bus_model.sv ***
// host side model: resolves the data bus and captures results
`timescale 1ns/100ps
module host_bus_model
(
    input  wire logic        clk_sys,
    input  wire logic        busy,
    input  wire logic [11:0] data_out,
    input  wire logic [11:0] data_oe_n,
    output logic      [11:0] bus_level,
    output logic      [11:0] captured
);
    logic [11:0] last_r;
    logic        busy_r;
    // undriven lines show the inverse of their last driven value
    assign bus_level = (data_oe_n & ~last_r) | (~data_oe_n & data_out);
    always_ff @(posedge clk_sys)
    begin
        last_r <= (data_oe_n & last_r) | (~data_oe_n & data_out);
        busy_r <= busy;
        if (busy && !busy_r)
        begin
            captured <= data_out;
        end
    end
endmodule
